// file: entry_if.sv
// Read path between the sequencer and the point-table store
`timescale 1ns/10ps
interface entry_if;
  import pts_pkg::*;
  logic [7:0] rd_idx;
  entry_s rd_data;
  modport table_side (input rd_idx, output rd_data);
  modport seq_side (output rd_idx, input rd_data);
endinterface

// file: entry_table.sv
// Point-table store: checked writes, one-cycle registered reads
`timescale 1ns/10ps
module entry_table
  import pts_pkg::*;
(
  // Clock
  input wire logic clk,
  // Write port
  input wire logic wr_en,
  input wire logic [7:0] wr_idx,
  input wire entry_s wr_data,
  input wire logic [1:0] unit,
  output logic wr_accept,
  // Read port
  entry_if.table_side rd
);

  entry_s mem [ENTRY_COUNT];

  // Bad codes, or out-of-range positions written while degrees are selected, never reach the table
  assign wr_accept = wr_en && aux_ok(wr_data.aux) && pos_ok(unit, wr_data.pos);

  always_ff @(posedge clk) begin
    if (wr_accept) begin
      mem[wr_idx] <= wr_data;
    end
  end

  always_ff @(posedge clk) begin
    rd.rd_data <= mem[rd.rd_idx];
  end

endmodule

// file: point_table_sequencer.sv
// Point-table positioning sequencer: start, chaining, dwell and completion code
`timescale 1ns/10ps
module point_table_sequencer
  import pts_pkg::*;
#(
  parameter int DWELL_TICK = DWELL_TICK_CYC,
  parameter logic [31:0] MAX_SPEED = 32'h00001770,
  parameter logic [31:0] PERMIT_SPEED = 32'h00001b58
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Host command objects
  input wire logic [15:0] mode_select,
  input wire logic [7:0] target_entry,
  input wire logic [15:0] control_word,
  // Configuration
  input wire logic travel_direction_select,
  input wire logic [1:0] position_unit_select,
  input wire logic speed_ramp_unit_select,
  input wire logic speed_range_limit_select,
  input wire logic linear_mode,
  input wire logic [15:0] gear_ratio,
  // Table write port
  input wire logic tbl_wr_en,
  input wire logic [7:0] tbl_wr_idx,
  input wire entry_s tbl_wr_data,
  // Motion feedback
  input wire logic motor_stopped,
  input wire logic smooth_zero,
  input wire logic cmd_done,
  // Motion command
  output logic motion_start_r,
  output logic signed [31:0] motion_target_r,
  output logic [31:0] motion_speed_r,
  output logic [31:0] motion_accel_r,
  output logic [31:0] motion_decel_r,
  output logic ramp_time_mode_r,
  output logic speed_mm_s_r,
  output logic [1:0] position_unit_r,
  output logic reverse_r,
  // Status
  output logic busy_r,
  output logic [7:0] active_entry_r,
  output logic [7:0] completion_code_r,
  output logic completion_pulse_r,
  output logic table_error_r,
  output logic write_reject_r
);

  typedef enum {ST_IDLE, ST_FETCH, ST_LOAD, ST_WAIT_ZERO, ST_MOVE, ST_DWELL} seq_state_e;

  seq_state_e state_r;
  seq_state_e state_nxt;
  entry_if rd_bus ();
  logic wr_accept;
  logic setpoint_prev_r;
  logic setpoint_rise;
  logic start_accept;
  logic [7:0] start_idx_r;
  logic [7:0] cur_idx_r;
  logic [7:0] next_idx;
  entry_s ent_r;
  logic signed [31:0] cmd_pos_r;
  logic signed [31:0] eff_pos;
  logic signed [31:0] target_nxt;
  logic rel_entry;
  logic dir_neg;
  logic moved_r;
  logic entry_bad;
  logic need_wait;
  logic launch;
  logic [47:0] speed_prod;
  logic [31:0] speed_unit;
  logic [31:0] speed_limit;
  logic [31:0] speed_nxt;
  logic [31:0] tick_r;
  logic [15:0] dwell_ms_r;
  logic chain_stop;

  // ----------------------------------------------------------------
  // Table store
  // ----------------------------------------------------------------
  entry_table u_table (
    .clk(clk),
    .wr_en(tbl_wr_en),
    .wr_idx(tbl_wr_idx),
    .wr_data(tbl_wr_data),
    .unit(position_unit_select),
    .wr_accept(wr_accept),
    .rd(rd_bus.table_side)
  );

  assign rd_bus.rd_idx = cur_idx_r;

  always_ff @(posedge clk) begin
    if (rst) begin
      write_reject_r <= 1'b0;
    end else begin
      write_reject_r <= tbl_wr_en && !wr_accept;
    end
  end

  // ----------------------------------------------------------------
  // Start detection
  // ----------------------------------------------------------------
  assign setpoint_rise = control_word[NEW_SETPOINT_BIT] && !setpoint_prev_r;
  // Only a rising edge counts, so a bit left high cannot restart a finished move
  assign start_accept = setpoint_rise && (mode_select == MODE_TABLE)
                        && (state_r == ST_IDLE) && motor_stopped;

  always_ff @(posedge clk) begin
    if (rst) begin
      setpoint_prev_r <= 1'b0;
    end else begin
      setpoint_prev_r <= control_word[NEW_SETPOINT_BIT];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      start_idx_r <= NO_ENTRY;
    end else if (start_accept) begin
      start_idx_r <= target_entry;
    end
  end

  // ----------------------------------------------------------------
  // Entry evaluation
  // ----------------------------------------------------------------
  assign rel_entry = rd_bus.rd_data.aux[1];
  assign eff_pos = travel_direction_select ? -rd_bus.rd_data.pos : rd_bus.rd_data.pos;
  assign target_nxt = rel_entry ? cmd_pos_r + eff_pos : eff_pos;
  assign dir_neg = target_nxt < cmd_pos_r;
  assign entry_bad = (cur_idx_r == NO_ENTRY) || !aux_ok(rd_bus.rd_data.aux)
                     || !pos_ok(position_unit_select, rd_bus.rd_data.pos)
                     || ((cur_idx_r == LAST_ENTRY) && ((rd_bus.rd_data.aux == AUX_NEXT_ABS)
                     || (rd_bus.rd_data.aux == AUX_NEXT_REL_B)));
  assign need_wait = moved_r && (dir_neg != reverse_r) && (target_nxt != cmd_pos_r);
  assign launch = ((state_r == ST_LOAD) && !entry_bad && !need_wait)
                  || ((state_r == ST_WAIT_ZERO) && smooth_zero);

  // Command-unit speed scaled by the gear ratio, fixed point below bit 16
  assign speed_prod = rd_bus.rd_data.speed * gear_ratio;
  assign speed_unit = (speed_ramp_unit_select == SPEED_UNIT_CMD) ?
                      speed_prod[GEAR_FRAC_BITS +: 32] : rd_bus.rd_data.speed;
  assign speed_limit = speed_range_limit_select ? PERMIT_SPEED : MAX_SPEED;
  assign speed_nxt = (speed_unit > speed_limit) ? speed_limit : speed_unit;

  // ----------------------------------------------------------------
  // Chaining
  // ----------------------------------------------------------------
  always_comb begin
    chain_stop = 1'b0;
    next_idx = cur_idx_r;
    case (ent_r.aux)
      AUX_NEXT_ABS, AUX_NEXT_REL, AUX_NEXT_REL_B: begin
        next_idx = cur_idx_r + 8'h01;
        chain_stop = (cur_idx_r == LAST_ENTRY);
      end
      AUX_START_ABS, AUX_START_REL: begin
        next_idx = start_idx_r;
      end
      AUX_FIRST_ABS, AUX_FIRST_REL: begin
        next_idx = FIRST_ENTRY;
      end
      default: begin
        chain_stop = 1'b1;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (start_accept) begin
          state_nxt = ST_FETCH;
        end
      end
      ST_FETCH: begin
        state_nxt = ST_LOAD;
      end
      ST_LOAD: begin
        if (entry_bad) begin
          state_nxt = ST_IDLE;
        end else if (need_wait) begin
          state_nxt = ST_WAIT_ZERO;
        end else begin
          state_nxt = ST_MOVE;
        end
      end
      ST_WAIT_ZERO: begin
        if (smooth_zero) begin
          state_nxt = ST_MOVE;
        end
      end
      ST_MOVE: begin
        if (cmd_done) begin
          if (chain_stop) begin
            state_nxt = ST_IDLE;
          end else if ((ent_r.dwell != 16'h0000) && (ent_r.aux != AUX_NEXT_REL)) begin
            state_nxt = ST_DWELL;
          end else begin
            state_nxt = ST_FETCH;
          end
        end
      end
      ST_DWELL: begin
        if (dwell_ms_r == ent_r.dwell) begin
          state_nxt = ST_FETCH;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_r <= ST_IDLE;
      busy_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      busy_r <= (state_nxt != ST_IDLE);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cur_idx_r <= NO_ENTRY;
    end else if (start_accept) begin
      cur_idx_r <= target_entry;
    end else if ((state_r == ST_MOVE) && cmd_done && !chain_stop) begin
      cur_idx_r <= next_idx;
    end
  end

  // ----------------------------------------------------------------
  // Dwell timing in whole milliseconds
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst || (state_r != ST_DWELL)) begin
      tick_r <= 32'h0;
      dwell_ms_r <= 16'h0;
    end else if (tick_r == 32'(DWELL_TICK - 1)) begin
      tick_r <= 32'h0;
      dwell_ms_r <= dwell_ms_r + 16'h1;
    end else begin
      tick_r <= tick_r + 32'h1;
    end
  end

  // ----------------------------------------------------------------
  // Motion command
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      ent_r <= '0;
    end else if ((state_r == ST_LOAD) && !entry_bad) begin
      ent_r <= rd_bus.rd_data;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      motion_start_r <= 1'b0;
      motion_target_r <= 32'sh0;
      motion_speed_r <= 32'h0;
      motion_accel_r <= 32'h0;
      motion_decel_r <= 32'h0;
      ramp_time_mode_r <= 1'b1;
      speed_mm_s_r <= 1'b0;
      position_unit_r <= UNIT_MM;
    end else begin
      motion_start_r <= launch;
      if ((state_r == ST_LOAD) && !entry_bad) begin
        motion_target_r <= target_nxt;
        motion_speed_r <= speed_nxt;
        motion_accel_r <= rd_bus.rd_data.accel;
        motion_decel_r <= rd_bus.rd_data.decel;
        ramp_time_mode_r <= (speed_ramp_unit_select == SPEED_UNIT_NATIVE);
        speed_mm_s_r <= linear_mode && (speed_ramp_unit_select == SPEED_UNIT_NATIVE);
        position_unit_r <= position_unit_select;
      end
    end
  end

  // Commanded position is tracked here; it is the base for relative entries
  always_ff @(posedge clk) begin
    if (rst) begin
      cmd_pos_r <= 32'sh0;
      reverse_r <= 1'b0;
      moved_r <= 1'b0;
    end else begin
      if (start_accept) begin
        moved_r <= 1'b0;
      end else if (launch) begin
        moved_r <= 1'b1;
      end
      if ((state_r == ST_LOAD) && !entry_bad) begin
        cmd_pos_r <= target_nxt;
        if (target_nxt != cmd_pos_r) begin
          reverse_r <= dir_neg;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Status
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      completion_code_r <= 8'h00;
      completion_pulse_r <= 1'b0;
    end else begin
      completion_pulse_r <= (state_r == ST_MOVE) && cmd_done;
      if ((state_r == ST_MOVE) && cmd_done) begin
        completion_code_r <= ent_r.mcode;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      active_entry_r <= NO_ENTRY;
      table_error_r <= 1'b0;
    end else begin
      if (launch) begin
        active_entry_r <= cur_idx_r;
      end
      // Error holds until the next accepted start
      if (start_accept) begin
        table_error_r <= 1'b0;
      end else if ((state_r == ST_LOAD) && entry_bad) begin
        table_error_r <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  start_gate_a: assert property ($rose(busy_r) |-> $past(motor_stopped)
    && ($past(mode_select) == MODE_TABLE))
    else $error("sequence started without table mode or stopped motor");

  start_hold_a: assert property (busy_r
    |=> start_idx_r == $past(start_idx_r))
    else $error("start entry changed during operation");

  reverse_wait_a: assert property ((state_r == ST_WAIT_ZERO) && !smooth_zero
    |=> !motion_start_r)
    else $error("reversal started before smoothed command reached zero");

  code_out_a: assert property ((state_r == ST_MOVE) && cmd_done
    |=> completion_pulse_r && (completion_code_r == $past(ent_r.mcode)))
    else $error("completion code not presented on completion");

  last_entry_a: assert property ((state_r == ST_LOAD) && (cur_idx_r == LAST_ENTRY)
    && ((rd_bus.rd_data.aux == AUX_NEXT_ABS) || (rd_bus.rd_data.aux == AUX_NEXT_REL_B))
    |=> table_error_r && !motion_start_r && (state_r == ST_IDLE))
    else $error("entry 255 chaining to next did not raise error");

  degree_range_a: assert property ((state_r == ST_LOAD)
    && !pos_ok(position_unit_select, rd_bus.rd_data.pos) |=> table_error_r ##1 !busy_r)
    else $error("degree position out of range was accepted");

  speed_clamp_a: assert property (motion_start_r && !speed_range_limit_select
    |-> motion_speed_r <= MAX_SPEED)
    else $error("speed above motor maximum");

  dwell_hold_a: assert property ((state_r == ST_DWELL) && (dwell_ms_r != ent_r.dwell)
    |=> !motion_start_r && (state_r == ST_DWELL))
    else $error("next entry started before dwell elapsed");

  chain_first_a: assert property ((state_r == ST_MOVE) && cmd_done
    && ((ent_r.aux == AUX_FIRST_ABS) || (ent_r.aux == AUX_FIRST_REL)) |=> cur_idx_r == FIRST_ENTRY)
    else $error("jump to entry 1 not taken");

  chain_start_a: assert property ((state_r == ST_MOVE) && cmd_done
    && ((ent_r.aux == AUX_START_ABS) || (ent_r.aux == AUX_START_REL))
    |=> (cur_idx_r == start_idx_r) ##1 (state_r == ST_LOAD) || (state_r == ST_DWELL))
    else $error("jump to start entry not taken");

  single_stop_a: assert property ((state_r == ST_MOVE) && cmd_done
    && (ent_r.aux == AUX_SINGLE_ABS) |=> (state_r == ST_IDLE) ##1 !busy_r)
    else $error("single entry did not stop");

endmodule

// file: pts_motion_model.sv
// Motion stage model: answers each move with done and smoothing status
`timescale 1ns/10ps
module pts_motion_model #(
  parameter int MOVE_CYC = 6
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic motion_start_r,
  input wire logic hold_run,
  input wire logic [31:0] lag,
  output logic motor_stopped,
  output logic smooth_zero,
  output logic cmd_done
);
  int cnt;
  int zcnt;
  always_ff @(posedge clk) begin
    cmd_done <= 1'b0;
    if (rst) begin
      cnt <= 0;
    end else if (motion_start_r) begin
      cnt <= MOVE_CYC;
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
      cmd_done <= (cnt == 1);
    end
  end
  // Smoothed command lags the move end, so a reversal must wait
  always_ff @(posedge clk) begin
    if (rst || cnt > 0) begin
      zcnt <= lag;
    end else if (zcnt > 0) begin
      zcnt <= zcnt - 1;
    end
  end
  assign motor_stopped = (cnt == 0) && !hold_run;
  assign smooth_zero = (cnt == 0) && (zcnt == 0);
endmodule

// file: pts_pkg.sv
// Constants, entry layout and shared checks for the point-table sequencer
package pts_pkg;

  // ----------------------------------------------------------------
  // Host command objects
  // ----------------------------------------------------------------
  localparam logic [15:0] MODE_TABLE = 16'hff9b;
  localparam int NEW_SETPOINT_BIT = 4;

  // ----------------------------------------------------------------
  // Table geometry
  // ----------------------------------------------------------------
  localparam int ENTRY_COUNT = 256;
  localparam logic [7:0] FIRST_ENTRY = 8'h01;
  localparam logic [7:0] LAST_ENTRY = 8'hff;
  localparam logic [7:0] NO_ENTRY = 8'h00;

  // ----------------------------------------------------------------
  // Auxiliary function codes
  // ----------------------------------------------------------------
  localparam logic [3:0] AUX_SINGLE_ABS = 4'h0;
  localparam logic [3:0] AUX_NEXT_ABS = 4'h1;
  localparam logic [3:0] AUX_NEXT_REL = 4'h2;
  localparam logic [3:0] AUX_NEXT_REL_B = 4'h3;
  localparam logic [3:0] AUX_START_ABS = 4'h8;
  localparam logic [3:0] AUX_FIRST_ABS = 4'h9;
  localparam logic [3:0] AUX_START_REL = 4'ha;
  localparam logic [3:0] AUX_FIRST_REL = 4'hb;

  // ----------------------------------------------------------------
  // Unit selections
  // ----------------------------------------------------------------
  localparam logic [1:0] UNIT_MM = 2'h0;
  localparam logic [1:0] UNIT_INCH = 2'h1;
  localparam logic [1:0] UNIT_DEGREE = 2'h2;
  localparam logic [1:0] UNIT_PULSE = 2'h3;
  localparam logic SPEED_UNIT_NATIVE = 1'h0;
  localparam logic SPEED_UNIT_CMD = 1'h1;
  localparam logic signed [31:0] DEG_POS_MAX = 32'sh00057e40;
  localparam logic signed [31:0] DEG_POS_MIN = 32'shfffa81c0;
  localparam int GEAR_FRAC_BITS = 16;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 20;
  localparam int DWELL_TICK_NS = 1000000;
  localparam int DWELL_TICK_CYC = DWELL_TICK_NS / CLK_PERIOD_NS;

  typedef struct packed {
    logic signed [31:0] pos;
    logic [31:0] speed;
    logic [31:0] accel;
    logic [31:0] decel;
    logic [15:0] dwell;
    logic [3:0] aux;
    logic [7:0] mcode;
  } entry_s;

  function automatic logic aux_ok(input logic [3:0] aux);
    aux_ok = (aux <= AUX_NEXT_REL_B) || ((aux >= AUX_START_ABS) && (aux <= AUX_FIRST_REL));
  endfunction

  function automatic logic pos_ok(input logic [1:0] unit, input logic signed [31:0] pos);
    pos_ok = (unit != UNIT_DEGREE) || ((pos >= DEG_POS_MIN) && (pos <= DEG_POS_MAX));
  endfunction

endpackage

// file: testbench.sv
// Self-checking bench for the point-table sequencer
`timescale 1ns/10ps
module testbench;
  import pts_pkg::*;
  localparam int TICK = 5;
  localparam int LAG = 12;
  logic clk, rst, travel_direction_select, speed_ramp_unit_select;
  logic speed_range_limit_select, linear_mode, tbl_wr_en, hold_run;
  logic motor_stopped, smooth_zero, cmd_done;
  logic [15:0] mode_select, control_word, gear_ratio;
  logic [7:0] target_entry, tbl_wr_idx;
  logic [1:0] position_unit_select;
  entry_s tbl_wr_data;
  logic motion_start_r, ramp_time_mode_r, speed_mm_s_r, reverse_r, busy_r;
  logic completion_pulse_r, table_error_r, write_reject_r;
  logic signed [31:0] motion_target_r;
  logic [31:0] motion_speed_r, motion_accel_r, motion_decel_r;
  logic [1:0] position_unit_r;
  logic [7:0] active_entry_r, completion_code_r;
  int num_errors, check_count, seed;
  int m_pos[256], m_spd[256], m_dw[256], m_aux[256], m_mc[256];
  int cur, st, gap, dmn, mn, cmdpos, tgt, nx, a, mc, dw;
  logic first, lastrev, rv;
  longint sp;

  point_table_sequencer #(.DWELL_TICK(TICK)) i_point_table_sequencer (
    .clk, .rst, .mode_select, .target_entry, .control_word,
    .travel_direction_select, .position_unit_select, .speed_ramp_unit_select,
    .speed_range_limit_select, .linear_mode, .gear_ratio, .tbl_wr_en,
    .tbl_wr_idx, .tbl_wr_data, .motor_stopped, .smooth_zero, .cmd_done,
    .motion_start_r, .motion_target_r, .motion_speed_r, .motion_accel_r,
    .motion_decel_r, .ramp_time_mode_r, .speed_mm_s_r, .position_unit_r,
    .reverse_r, .busy_r, .active_entry_r, .completion_code_r,
    .completion_pulse_r, .table_error_r, .write_reject_r);
  pts_motion_model i_pts_motion_model (
    .clk, .rst, .motion_start_r, .hold_run, .lag(LAG),
    .motor_stopped, .smooth_zero, .cmd_done);

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic tick;
    @(posedge clk);
    #1;
  endtask
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [7:0] i, input int p, input int s, input logic [15:0] d,
                    input logic [3:0] x, input logic [7:0] m);
    logic ok;
    ok = (x <= 3 || (x >= 8 && x <= 11)) && (position_unit_select != 2 ||
         (p >= -360000 && p <= 360000));
    tbl_wr_en = 1'b1;
    tbl_wr_idx = i;
    tbl_wr_data = '{pos:p, speed:s, accel:100, decel:150, dwell:d, aux:x, mcode:m};
    tick;
    tbl_wr_en = 1'b0;
    chk("reject", write_reject_r, !ok);
    if (ok) begin
      m_pos[i] = p;
      m_spd[i] = s;
      m_dw[i] = d;
      m_aux[i] = x;
      m_mc[i] = m;
    end
    tick;
  endtask
  task automatic go(input logic [7:0] e);
    cur = e;
    st = e;
    first = 1'b1;
    target_entry = e;
    control_word[NEW_SETPOINT_BIT] = 1'b1;
    tick;
    control_word[NEW_SETPOINT_BIT] = 1'b0;
    tick;
  endtask
  task automatic idle;
    int n;
    n = 0;
    while (busy_r !== 1'b0 && n < 3000) begin
      tick;
      n++;
    end
    chk("idle", n < 3000, 1);
    tick;
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Reference model, checked at every launch and completion
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    gap++;
    if (motion_start_r === 1'b1) begin
      // Latch the entry as the design does; the host may rewrite it mid-move
      a = m_aux[cur];
      mc = m_mc[cur];
      dw = m_dw[cur];
      tgt = (a[1] ? cmdpos : 0) + (travel_direction_select ? -m_pos[cur] : m_pos[cur]);
      sp = speed_ramp_unit_select ? (longint'(m_spd[cur]) * gear_ratio) >> 16 : m_spd[cur];
      if (sp > (speed_range_limit_select ? 32'h00001b58 : 32'h00001770)) begin
        sp = speed_range_limit_select ? 32'h00001b58 : 32'h00001770;
      end
      rv = tgt < cmdpos;
      mn = (!first && tgt != cmdpos && rv != lastrev && LAG > dmn) ? LAG : dmn;
      chk("entry", active_entry_r, cur[7:0]);
      chk("target", motion_target_r, tgt);
      chk("speed", motion_speed_r, sp[31:0]);
      chk("ramps", {motion_accel_r[15:0], motion_decel_r[15:0]}, 32'h00640096);
      chk("ramp_ms", ramp_time_mode_r, !speed_ramp_unit_select);
      chk("mm_s", speed_mm_s_r, linear_mode && !speed_ramp_unit_select);
      chk("unit", position_unit_r, position_unit_select);
      if (!first) begin
        chk("gap", gap >= mn && gap <= mn + 4, 1);
      end
      if (tgt != cmdpos) begin
        chk("reverse", reverse_r, rv);
        lastrev = rv;
      end
      cmdpos = tgt;
      first = 1'b0;
    end
    if (completion_pulse_r === 1'b1) begin
      chk("mcode", completion_code_r, mc);
      nx = 0;
      if (a inside {1, 2, 3} && cur < 255) begin
        nx = cur + 1;
      end
      if (a inside {8, 10}) begin
        nx = st;
      end
      if (a inside {9, 11}) begin
        nx = 1;
      end
      chk("busy", busy_r, nx != 0);
      dmn = 2 + ((a == 2) ? 0 : dw * TICK);
      cur = nx;
      gap = 0;
    end
  end

  initial begin
    #(20 * 30000);
    num_errors++;
    results;
  end

  initial begin
    {rst, travel_direction_select, speed_ramp_unit_select, hold_run} = 4'hf;
    {speed_range_limit_select, linear_mode, tbl_wr_en} = 3'h0;
    travel_direction_select = 1'b0;
    speed_ramp_unit_select = 1'b0;
    hold_run = 1'b0;
    mode_select = MODE_TABLE;
    control_word = 16'h0000;
    gear_ratio = 16'h8000;
    target_entry = 8'h00;
    tbl_wr_idx = 8'h00;
    tbl_wr_data = '0;
    position_unit_select = 2'h3;
    {num_errors, check_count, cmdpos, gap, dmn} = '0;
    lastrev = 1'b0;
    seed = $urandom(55);
    repeat (4) @(posedge clk);
    #1;
    rst = 1'b0;
    chk("rst_out", {ramp_time_mode_r, busy_r, table_error_r, position_unit_r}, 5'h10);
    chk("rst_code", completion_code_r, 0);
    $display("test reset done");
    for (int k = 0; k < 16; k++) begin
      wr(8'h0a, 10, 100, 16'h0000, k[3:0], 8'h00);
    end
    position_unit_select = 2'h2;
    wr(8'h08, 360001, 100, 16'h0000, 4'h0, 8'h01);
    wr(8'h08, -360000, 100, 16'h0000, 4'h0, 8'h21);
    go(8'h08);
    idle;
    position_unit_select = 2'h3;
    $display("test table writes done");
    wr(8'h07, $urandom_range(2000), 100, 16'h0000, 4'h0, 8'($urandom_range(255)));
    go(8'h07);
    idle;
    travel_direction_select = 1'b1;
    go(8'h07);
    idle;
    travel_direction_select = 1'b0;
    $display("test single and direction done");
    wr(8'h05, 3000, 100, 16'h0000, 4'h9, 8'h11);
    wr(8'h01, 1000, 100, 16'h0002, 4'h1, 8'h12);
    wr(8'h02, -300, 100, 16'h0003, 4'h2, 8'h13);
    wr(8'h03, 200, 100, 16'h0000, 4'h0, 8'h14);
    go(8'h05);
    idle;
    $display("test chaining done");
    wr(8'h03, 250, 100, 16'h0000, 4'h8, 8'h15);
    go(8'h03);
    target_entry = 8'h09;
    for (int n = 0; n < 100 && motion_start_r !== 1'b1; n++) begin
      tick;
    end
    wr(8'h03, 100, 100, 16'h0000, 4'h0, 8'h16);
    idle;
    $display("test loop to start done");
    hold_run = 1'b1;
    go(8'h07);
    hold_run = 1'b0;
    chk("rotating", busy_r, 0);
    mode_select = 16'h0001;
    go(8'h07);
    mode_select = MODE_TABLE;
    chk("mode", busy_r, 0);
    wr(8'h04, 400000, 100, 16'h0000, 4'h0, 8'h00);
    position_unit_select = 2'h2;
    go(8'h04);
    tick;
    chk("deg_err", table_error_r, 1);
    position_unit_select = 2'h3;
    wr(8'hff, 10, 100, 16'h0000, 4'h1, 8'h00);
    go(8'hff);
    tick;
    chk("tbl_err", table_error_r, 1);
    idle;
    $display("test refusals done");
    wr(8'h06, 0, 8192, 16'h0000, 4'h0, 8'h33);
    for (int k = 0; k < 4; k++) begin
      speed_ramp_unit_select = k[1];
      speed_range_limit_select = k[0];
      linear_mode = !k[0];
      gear_ratio = 16'($urandom_range(16'hffff, 16'h4000));
      go(8'h06);
      idle;
      chk("err_clr", table_error_r, 0);
    end
    $display("test speed units done");
    results;
  end
endmodule
